// *** scpc_pkg.sv ***
// shared constants and types for the converter control block
package scpc_pkg;

    // conversion length in internal clock cycles (plain default)
    localparam int unsigned CONV_CYCLES = 40;
    localparam int unsigned CNT_W       = 6;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_RST  = 6'h00;
    // synchroniser preset: every pin at its idle level, start pin high
    localparam logic [6:0] SYNC_RST = 7'h40;

    typedef enum logic [1:0] {
        SCPC_IDLE,
        SCPC_CONV,
        SCPC_HALT
    } scpc_state_t;

    // power enables for the analog blocks
    typedef struct packed {
        logic bandgapOn;
        logic refBufferOn;
        logic tempSensorOn;
        logic coreOn;
    } scpc_power_t;

    localparam scpc_power_t POWER_RST = 4'h0;

endpackage : scpc_pkg

// *** scpc_control.sv ***
// conversion start, conversion run and power state control
//
// What this block does
// - a falling edge on convert_start_n alone starts a conversion while idle with no power-down request
// - a running conversion completes unless reset rises; no start edge or power-down aborts it
// - chip select and read enable never gate the conversion start
// - power-down high enters power-down with supply currents minimal
// - power-down waits for a running conversion; digital side stays active
// - register power-down bit replaces the pin while register config is used
// - low-power sampling mode cuts core power after each conversion
// - digital interface stays functional during acquisition in every mode
// - reference and buffer off low: bandgap, buffer and sensor enabled
// - reference off high, buffer off low: only the buffer enabled
// - each off input powers down its own block independently
// - fast low with low-power high selects low-power mode, else normal
// - reset rising edge aborts conversion; falling edge clears configuration
`timescale 1ns/1ps

module scpc_control
    import scpc_pkg::*;
(
    input  wire logic        ref_clk,          // 40 MHz clock
    input  wire logic        srst,             // synchronous reset, high
    input  wire logic        convert_start_n,  // pin, start on falling edge
    input  wire logic        power_down_input, // pin, power-down request
    input  wire logic        reference_off,    // pin, internal reference off
    input  wire logic        buffer_off,       // pin, reference buffer off
    input  wire logic        fastMode,         // pin, fast mode select
    input  wire logic        lowPowerMode,     // pin, low-power mode select
    input  wire logic        chipSelect_n,     // pin, unused for starts
    input  wire logic        readEnable_n,     // pin, unused for starts
    input  wire logic        devReset,         // pin, device reset level
    input  wire logic        useConfigReg,     // register config in use
    input  wire logic        cfgPowerDown,     // configuration power-down bit
    output logic             busy,             // conversion in progress
    output logic             resultReady,      // one-cycle pulse at end
    output logic             poweredDown,      // power-down state
    output logic             dataBusOff,       // data bus tristated
    output logic             cfgClear,         // pulse: clear config register
    output logic             digitalActive,    // digital interface enabled
    output scpc_power_t      power             // analog power enables
);

    // two-flop synchronisers for every pin except chip select and read enable
    logic [6:0] syncA_q;
    logic [6:0] syncB_q;
    logic [6:0] pinIn;
    logic cnvS, pdS, refOffS, bufOffS, fastS, lowS, rstS;

    assign pinIn = {convert_start_n, power_down_input, reference_off,
                    buffer_off, fastMode, lowPowerMode, devReset};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            // idle levels, so no false reset or power-down edge follows
            syncA_q <= SYNC_RST;
            syncB_q <= SYNC_RST;
        end else begin
            syncA_q <= pinIn;
            syncB_q <= syncA_q;
        end
    end

    assign {cnvS, pdS, refOffS, bufOffS, fastS, lowS, rstS} = syncB_q;

    // edge history
    logic cnvPrev_q, cnvPrev_d;
    logic rstPrev_q, rstPrev_d;
    logic startEdge, rstRise, rstFall;

    // no chip select or read term here
    assign startEdge = cnvPrev_q & ~cnvS;
    assign rstRise   = ~rstPrev_q & rstS;
    assign rstFall   = rstPrev_q & ~rstS;

    // conversion state
    scpc_state_t     state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic            ready_q, ready_d;
    logic            pd_q, pd_d;
    logic            busOff_q, busOff_d;
    logic            clr_q, clr_d;
    logic            pdReq, lowPwr;

    assign pdReq  = useConfigReg ? cfgPowerDown : pdS;
    assign lowPwr = ~fastS & lowS;

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        ready_d   = 1'b0;
        cnvPrev_d = cnvS;
        rstPrev_d = rstS;
        pd_d      = pd_q;
        busOff_d  = busOff_q;
        clr_d     = 1'b0;
        case (state_q)
            SCPC_IDLE: begin
                pd_d = pdReq;
                if (startEdge && !pdReq) begin
                    state_d = SCPC_CONV;
                    cnt_d   = CNT_RST;
                    pd_d    = 1'b0;
                end
            end
            SCPC_CONV: begin
                // runs to the end unless reset rises; starts ignored while busy
                if (cnt_q == CNT_LAST) begin
                    state_d = SCPC_IDLE;
                    ready_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            SCPC_HALT: begin
                if (!rstS) begin
                    state_d = SCPC_IDLE;
                end
            end
            default: state_d = SCPC_IDLE;
        endcase
        if (rstRise) begin
            state_d  = SCPC_HALT;
            busOff_d = 1'b1;
            ready_d  = 1'b0;
        end
        if (rstFall) begin
            clr_d    = 1'b1;
            busOff_d = 1'b0;
            pd_d     = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q   <= SCPC_IDLE;
            cnt_q     <= CNT_RST;
            ready_q   <= 1'b0;
            cnvPrev_q <= 1'b1;
            rstPrev_q <= 1'b0;
            pd_q      <= 1'b0;
            busOff_q  <= 1'b0;
            clr_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            ready_q   <= ready_d;
            cnvPrev_q <= cnvPrev_d;
            rstPrev_q <= rstPrev_d;
            pd_q      <= pd_d;
            busOff_q  <= busOff_d;
            clr_q     <= clr_d;
        end
    end

    // power enables
    scpc_power_t power_q, power_d;
    logic        conv;

    assign conv = (state_q == SCPC_CONV);

    always_comb begin
        power_d = POWER_RST;
        if (!pd_q) begin
            // each off input drives its own block
            power_d.bandgapOn    = ~refOffS;
            power_d.tempSensorOn = ~refOffS;
            power_d.refBufferOn  = ~bufOffS;
            // low-power mode powers the core only while converting
            power_d.coreOn = lowPwr ? conv : 1'b1;
        end
        // powered down: all analog blocks off, except the core while converting
        if (pd_q && conv) begin
            power_d.coreOn = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            power_q <= POWER_RST;
        end else begin
            power_q <= power_d;
        end
    end

    assign busy        = conv;
    assign resultReady = ready_q;
    assign poweredDown = pd_q;
    assign dataBusOff  = busOff_q;
    assign cfgClear    = clr_q;
    // digital side never gated by mode or power-down
    assign digitalActive = 1'b1;
    assign power       = power_q;

    start_busy_a: assert property (@(posedge ref_clk)
        disable iff (srst)
        (state_q == SCPC_IDLE && startEdge && !pdReq && !rstRise)
            |=> busy)
        else $error("start edge did not raise busy");

    // start taken with the bus selected
    start_free_a: assert property (@(posedge ref_clk)
        disable iff (srst)
        (state_q == SCPC_IDLE && startEdge && !pdReq && !rstRise
            && !chipSelect_n && !readEnable_n) |=> busy)
        else $error("start gated by chip select or read enable");

    // busy ends only at the last count or on a reset abort
    conv_length_a: assert property (@(posedge ref_clk)
        disable iff (srst)
        $fell(busy) |-> ($past(cnt_q) == CNT_LAST || $past(rstRise)))
        else $error("conversion ended early");

    ready_end_a: assert property (@(posedge ref_clk)
        disable iff (srst)
        resultReady |-> !busy && $past(busy))
        else $error("ready without completed conversion");

    pd_hold_a: assert property (@(posedge ref_clk)
        disable iff (srst)
        (busy && !rstFall) |=> !$rose(poweredDown))
        else $error("power-down during conversion");

    core_cut_a: assert property (@(posedge ref_clk)
        disable iff (srst)
        ($past(lowPwr) && !$past(busy) && !$past(busy, 2))
            |-> !power.coreOn)
        else $error("core powered during low-power acquisition");

    ref_enable_a: assert property (@(posedge ref_clk)
        disable iff (srst)
        (!pd_q && !refOffS && !bufOffS) |=>
            ($past(pd_q) || (power.bandgapOn && power.refBufferOn)))
        else $error("internal reference not enabled");

    buf_off_a: assert property (@(posedge ref_clk)
        disable iff (srst)
        bufOffS |=> !power.refBufferOn)
        else $error("buffer on while buffer_off high");

    reset_abort_a: assert property (@(posedge ref_clk)
        disable iff (srst)
        rstRise |=> !busy && dataBusOff)
        else $error("reset rise did not abort");

endmodule : scpc_control

// *** scpc_host.sv ***
// host controller model driving start, power-down and mode pins
`timescale 1ns/1ps

module scpc_host
    import scpc_pkg::*;
(
    input  wire logic ref_clk,          // converter clock
    output logic      convert_start_n,  // start pin, falls to request
    output logic      power_down_input, // power-down pin
    output logic      fastMode,         // fast mode pin
    output logic      lowPowerMode      // low-power mode pin
);
    initial begin
        convert_start_n  = 1'b1;
        power_down_input = 1'b0;
        fastMode         = 1'b0;
        lowPowerMode     = 1'b0;
    end

    task automatic startEdge();
        @(posedge ref_clk);
        #1 convert_start_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 convert_start_n = 1'b1;
    endtask : startEdge

    task automatic setPins(input logic pd, input logic fm, input logic lp);
        @(posedge ref_clk);
        #1 power_down_input = pd;
        fastMode = fm;
        lowPowerMode = lp;
    endtask : setPins
endmodule : scpc_host

// *** scpc_control_test.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ps

module scpc_control_test
    import scpc_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        convStartN, pdPin, fastMode, lowPowerMode;
    logic        refOff = 1'b0, bufOff = 1'b0, csN = 1'b1, rdN = 1'b1;
    logic        devReset = 1'b0, useCfg = 1'b0, cfgPd = 1'b0;
    logic        busy, resultReady, poweredDown, dataBusOff, cfgClear;
    logic        digitalActive;
    scpc_power_t power;
    int          fail_count = 0, samples_checked = 0, busyCnt = 0;

    always #12.5 ref_clk = ~ref_clk;
    // counts the cycles of the current busy period, cleared while idle
    always @(posedge ref_clk)
        busyCnt <= (busy === 1'b1) ? busyCnt + 1 : 0;

    scpc_host u_scpc_host (.ref_clk(ref_clk), .convert_start_n(convStartN),
        .power_down_input(pdPin), .fastMode(fastMode),
        .lowPowerMode(lowPowerMode));

    scpc_control u_scpc_control (.ref_clk(ref_clk), .srst(srst),
        .convert_start_n(convStartN), .power_down_input(pdPin),
        .reference_off(refOff), .buffer_off(bufOff), .fastMode(fastMode),
        .lowPowerMode(lowPowerMode), .chipSelect_n(csN), .readEnable_n(rdN),
        .devReset(devReset), .useConfigReg(useCfg), .cfgPowerDown(cfgPd),
        .busy(busy), .resultReady(resultReady), .poweredDown(poweredDown),
        .dataBusOff(dataBusOff), .cfgClear(cfgClear),
        .digitalActive(digitalActive), .power(power));

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic chk(input string nm, input logic [31:0] ex, got);
        samples_checked++;
        if (got !== ex) begin
            $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
            fail_count++;
        end
    endtask : chk

    task automatic results();
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    task automatic waitIdle();
        for (int n = 0; busy !== 1'b0; n++) begin
            if (n > 100) begin
                fail_count++;
                results();
            end
            step(1);
        end
    endtask : waitIdle

    // one conversion, optionally with a second edge or power-down inside
    task automatic conv(input logic extra, input logic pdMid);
        u_scpc_host.startEdge();
        step(1);
        chk("coreOn busy", 1, power.coreOn);
        if (extra)
            u_scpc_host.startEdge();
        if (pdMid)
            u_scpc_host.setPins(1'b1, fastMode, lowPowerMode);
        waitIdle();
        chk("busyCnt", CONV_CYCLES, busyCnt);
        chk("resultReady", 1, resultReady);
        step(1);
        chk("ready pulse", 0, resultReady);
        chk("busy after", 0, busy);
    endtask : conv

    initial begin
        step(10);
        srst = 1'b0;
        step(6);
        chk("digitalActive", 1, digitalActive);
        chk("power", 4'hf, power);
        for (int i = 0; i < 3; i++) begin
            refOff = (i > 0);
            bufOff = (i == 2);
            step(6);
            chk("refPower", {~refOff, ~bufOff, ~refOff}, power[3:1]);
        end
        refOff = 1'b0;
        bufOff = 1'b0;
        conv(1'b0, 1'b0);
        csN = 1'b0;
        rdN = 1'b0;
        conv(1'b1, 1'b0);
        conv(1'b0, 1'b1);
        step(3);
        chk("poweredDown", 1, poweredDown);
        chk("coreOn pd", 0, power.coreOn);
        u_scpc_host.startEdge();
        step(4);
        chk("busy pd", 0, busy);
        u_scpc_host.setPins(1'b0, 1'b0, 1'b1);
        step(4);
        conv(1'b0, 1'b0);
        step(2);
        chk("coreOn acq", 0, power.coreOn);
        chk("digital acq", 1, digitalActive);
        u_scpc_host.setPins(1'b1, 1'b1, 1'b1);
        useCfg = 1'b1;
        step(4);
        chk("cfg pin", 0, poweredDown);
        chk("coreOn normal", 1, power.coreOn);
        cfgPd = 1'b1;
        step(4);
        chk("cfg bit", 1, poweredDown);
        cfgPd = 1'b0;
        u_scpc_host.setPins(1'b0, 1'b1, 1'b1);
        step(4);
        u_scpc_host.startEdge();
        step(5);
        devReset = 1'b1;
        step(4);
        chk("busy abort", 0, busy);
        chk("busOff", 1, dataBusOff);
        devReset = 1'b0;
        for (int n = 0; n < 6 && cfgClear !== 1'b1; n++)
            step(1);
        chk("cfgClear", 1, cfgClear);
        step(1);
        chk("busOff off", 0, dataBusOff);
        results();
    end
endmodule : scpc_control_test
